/* File: rtl/hcl_pkg.sv */
// Purpose: Shared constants and types for the hue and chroma loop control block
// Assumes: 32-bit APB with 12-bit byte addresses, 100 MHz clock
// Notes:   Phase words are 16 bits, one full turn of the subcarrier per wrap

package hcl_pkg;

    // Register byte addresses
    localparam logic [11:0] ADDR_TINT       = 12'h03c;
    localparam logic [11:0] ADDR_EVEN_LOOP  = 12'h040;
    localparam logic [11:0] ADDR_ODD_LOOP   = 12'h0c0;

    // Reset values
    localparam logic [7:0]  TINT_RESET      = 8'h00;
    localparam logic [7:0]  LOOP_RESET      = 8'h00;

    // Bus widths
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam logic [23:0] READ_PAD        = 24'h000000;

    // One tint step is 1/512 turn (about 0.7 degrees) of a 16-bit phase word
    localparam int          PHASE_W         = 16;
    localparam int          TINT_SHIFT      = 7;

    // Chroma gain in 2.8 fixed point, held between 0.5 and 2.0
    localparam int          GAIN_FRAC       = 8;
    localparam logic [9:0]  GAIN_UNITY      = 10'h100;
    localparam logic [9:0]  GAIN_MIN        = 10'h080;
    localparam logic [9:0]  GAIN_MAX        = 10'h200;
    localparam logic signed [20:0] CHROMA_HI = 21'sh0001ff;
    localparam logic signed [20:0] CHROMA_LO = -21'sh000200;
    localparam logic signed [9:0]  CHROMA_ZERO = 10'sh000;

    // Horizontal scale ratio, output/input width in 1.15 fixed point
    localparam logic [15:0] RATIO_HALF      = 16'h4000;
    localparam logic [15:0] RATIO_QUARTER   = 16'h2000;
    localparam logic [15:0] RATIO_EIGHTH    = 16'h1000;

    // Horizontal filter select field codes
    localparam logic [1:0]  HF_AUTO         = 2'h0;
    localparam logic [1:0]  HF_CODE1        = 2'h1;
    localparam logic [1:0]  HF_CODE2        = 2'h2;

    // Decoding standard of the current input
    typedef enum logic [1:0] {
        std_ntsc,
        std_pal,
        std_secam,
        std_digital
    } hcl_std_t;

    // Luma filter actually applied
    typedef enum logic [2:0] {
        filt_none,
        filt_cif,
        filt_qcif,
        filt_icon,
        filt_peak_max_full,
        filt_peak_min_cif,
        filt_peak_min_full
    } hcl_filter_t;

    // Register selected by an address
    typedef enum logic [1:0] {
        sel_none,
        sel_tint,
        sel_even,
        sel_odd
    } hcl_sel_t;

    // Loop control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic       peak;
        logic       chroma_gain_loop_enable;
        logic       low_color_removal_enable;
        logic [1:0] horizontal_lowpass_select;
        logic [2:0] reserved;
    } hcl_loop_ctrl_t;

    // APB request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } hcl_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } hcl_apb_rsp_t;

    // Whole state of the control block
    typedef struct packed {
        logic [7:0]          tint;
        hcl_loop_ctrl_t      even_ctrl;
        hcl_loop_ctrl_t      odd_ctrl;
        logic [DATA_W-1:0]   prdata;
        logic [PHASE_W-1:0]  demod_phase;
        logic signed [9:0]   chroma_out;
        hcl_filter_t         filter_sel;
        logic                peaking_enable;
        logic                gain_enable;
        logic                kill_enable;
        logic                tint_written;
    } hcl_state_t;

endpackage

/* File: rtl/hcl_filter_select.sv */
// Purpose: Picks the luma filter from one loop control byte and the scale ratio
// Assumes: Ratio is output/input width, 1.15 fixed point
// Notes:   Purely combinational; the caller registers the result

`timescale 1ns/1ps
`default_nettype none

module hcl_filter_select
    import hcl_pkg::*;
(
    // Settings in
    input  wire hcl_loop_ctrl_t ctrl,
    input  wire logic [15:0]    hscale_ratio,
    // Choice out
    output hcl_filter_t         filter_sel
);

    // Filter decode per field settings
    always_comb begin
        filter_sel = filt_none;
        // [R14] reserved bits unused
        if (ctrl.peak) begin
            // [R12] peaking filter choice
            case (ctrl.horizontal_lowpass_select)
                HF_CODE1: filter_sel = filt_peak_max_full;
                HF_CODE2: filter_sel = filt_peak_min_cif;
                // Codes 0 and 3 fall back to the mildest peaking
                default:  filter_sel = filt_peak_min_full;
            endcase
        end else begin
            // [R6] normal low-pass path
            case (ctrl.horizontal_lowpass_select)
                HF_AUTO: begin
                    // [R10] auto from scale ratio
                    if (hscale_ratio > RATIO_HALF) begin
                        filter_sel = filt_none;
                    end else if (hscale_ratio > RATIO_QUARTER) begin
                        filter_sel = filt_cif;
                    end else if (hscale_ratio > RATIO_EIGHTH) begin
                        filter_sel = filt_qcif;
                    end else begin
                        filter_sel = filt_icon;
                    end
                end
                // [R9] manual filter codes
                HF_CODE1: filter_sel = filt_cif;
                HF_CODE2: filter_sel = filt_qcif;
                default:  filter_sel = filt_icon;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: rtl/hcl_loop_control.sv */
// Purpose: Tint offset and per-field chroma loop control registers over APB
// Assumes: Decoder signals come from logic on clk; APB master on clk
// Notes:   Zero-wait APB slave; read data is latched in the setup cycle
//
// Notes on behaviour
// [R1] Signed tint byte adds to demod phase
// [R2] 256 steps of 0.7 degrees, 0x80 most negative
// [R3] Tint register resets to zero
// [R4] Tint acts only on NTSC-style decoding
// [R5] Separate even and odd loop control registers
// [R6] Bit 7 picks peaking or low-pass filters
// [R7] Bit 6 enables chroma gain 0.5 to 2.0
// [R8] Bit 5 enables low colour removal
// [R9] Bits 4:3 pick filter, 00 is auto
// [R10] Auto mode picks filter from scale ratio
// [R11] Software clears luma decimation before filtering
// [R12] With peaking, bits 4:3 pick peaking filter
// [R13] Each field uses its own register copy
// [R14] Bits 2:0 reserved, reset zero, no effect
//
// Local design decision: the APB register port.

`timescale 1ns/1ps
`default_nettype none

module hcl_loop_control
    import hcl_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Register bus
    input  wire hcl_apb_req_t       apb_req,
    output var  hcl_apb_rsp_t       apb_rsp,
    // Decoder status in
    input  wire logic               field_odd,
    input  wire hcl_std_t           color_std,
    input  wire logic [15:0]        sc_phase,
    input  wire logic [15:0]        hscale_ratio,
    // Chroma path in
    input  wire logic signed [9:0]  chroma_in,
    input  wire logic [9:0]         chroma_gain,
    input  wire logic               low_color_detected,
    // Phase and chroma out
    output logic [15:0]             demod_phase,
    output logic signed [9:0]       chroma_out,
    // Active settings out
    output hcl_filter_t             filter_sel,
    output logic                    peaking_enable,
    output logic                    chroma_gain_loop_enable,
    output logic                    low_color_removal_enable
);

    // Register state and its next value
    hcl_state_t     state_reg;
    hcl_state_t     state_next;

    // Settings of the field being decoded
    hcl_loop_ctrl_t active_ctrl;
    // Filter choice for those settings
    hcl_filter_t    filter_pick;
    // Bus phase decode
    hcl_sel_t       bus_sel;
    logic           setup_phase;
    logic           access_phase;
    logic           bus_write;

    // Address to register select
    function automatic hcl_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        hcl_sel_t sel;
        case (addr)
            ADDR_TINT:      sel = sel_tint;
            ADDR_EVEN_LOOP: sel = sel_even;
            ADDR_ODD_LOOP:  sel = sel_odd;
            default:        sel = sel_none;
        endcase
        return sel;
    endfunction

    // Tint byte as a phase word offset
    function automatic logic [PHASE_W-1:0] tint_offset(input logic [7:0] tint);
        logic signed [PHASE_W-1:0] wide;
        wide = PHASE_W'($signed(tint));
        return PHASE_W'(wide <<< TINT_SHIFT);
    endfunction

    // Clamp the gain to its legal window
    function automatic logic [9:0] clamp_gain(input logic [9:0] gain);
        logic [9:0] g;
        g = gain;
        if (g < GAIN_MIN) begin
            g = GAIN_MIN;
        end else if (g > GAIN_MAX) begin
            g = GAIN_MAX;
        end
        return g;
    endfunction

    // Multiply chroma by gain with saturation
    function automatic logic signed [9:0] apply_gain(input logic signed [9:0] c,
                                                     input logic [9:0] gain);
        logic signed [20:0] prod;
        logic signed [20:0] scaled;
        prod = 21'(c) * 21'($signed({1'b0, clamp_gain(gain)}));
        scaled = prod >>> GAIN_FRAC;
        if (scaled > CHROMA_HI) begin
            scaled = CHROMA_HI;
        end else if (scaled < CHROMA_LO) begin
            scaled = CHROMA_LO;
        end
        return scaled[9:0];
    endfunction

    // Bus phases
    assign bus_sel      = decode_addr(apb_req.paddr);
    assign setup_phase  = apb_req.psel && !apb_req.penable;
    assign access_phase = apb_req.psel && apb_req.penable;
    assign bus_write    = access_phase && apb_req.pwrite;

    // [R13] field picks register copy
    assign active_ctrl = field_odd ? state_reg.odd_ctrl : state_reg.even_ctrl;

    // Filter decode for the active field
    hcl_filter_select u_filter_select (
        .ctrl         (active_ctrl),
        .hscale_ratio (hscale_ratio),
        .filter_sel   (filter_pick)
    );

    // Next state
    always_comb begin
        state_next = state_reg;

        // Writes take effect at the access edge only
        if (bus_write) begin
            case (bus_sel)
                sel_tint: begin
                    state_next.tint         = apb_req.pwdata[7:0];
                    state_next.tint_written = 1'b1;
                end
                // [R5] two independent copies
                sel_even: state_next.even_ctrl = hcl_loop_ctrl_t'(apb_req.pwdata[7:0]);
                sel_odd:  state_next.odd_ctrl  = hcl_loop_ctrl_t'(apb_req.pwdata[7:0]);
                default:  state_next.tint = state_reg.tint;  // Unmapped writes are dropped
            endcase
        end

        // Read data latched in setup so it comes from a flop
        if (setup_phase) begin
            case (bus_sel)
                sel_tint: state_next.prdata = {READ_PAD, state_reg.tint};
                sel_even: state_next.prdata = {READ_PAD, state_reg.even_ctrl};
                sel_odd:  state_next.prdata = {READ_PAD, state_reg.odd_ctrl};
                default:  state_next.prdata = '0;
            endcase
        end

        // [R1] add tint to subcarrier phase
        // [R4] only for NTSC-style input
        if (color_std == std_ntsc) begin
            // [R2] 0x80 gives the most negative shift
            state_next.demod_phase = sc_phase + tint_offset(state_reg.tint);
        end else begin
            state_next.demod_phase = sc_phase;
        end

        // [R8] low colour removal wins over gain
        if (active_ctrl.low_color_removal_enable && low_color_detected) begin
            state_next.chroma_out = CHROMA_ZERO;
        end else if (active_ctrl.chroma_gain_loop_enable) begin
            // [R7] gain clamped to 0.5..2.0
            state_next.chroma_out = apply_gain(chroma_in, chroma_gain);
        end else begin
            state_next.chroma_out = chroma_in;
        end

        // [R6] active filter and flags
        state_next.filter_sel     = filter_pick;
        state_next.peaking_enable = active_ctrl.peak;
        state_next.gain_enable    = active_ctrl.chroma_gain_loop_enable;
        state_next.kill_enable    = active_ctrl.low_color_removal_enable;
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // [R3] tint clears at reset
            state_reg.tint           <= TINT_RESET;
            // [R14] reserved bits reset zero
            state_reg.even_ctrl      <= hcl_loop_ctrl_t'(LOOP_RESET);
            state_reg.odd_ctrl       <= hcl_loop_ctrl_t'(LOOP_RESET);
            state_reg.prdata         <= '0;
            state_reg.demod_phase    <= '0;
            state_reg.chroma_out     <= CHROMA_ZERO;
            state_reg.filter_sel     <= filt_none;
            state_reg.peaking_enable <= 1'b0;
            state_reg.gain_enable    <= 1'b0;
            state_reg.kill_enable    <= 1'b0;
            state_reg.tint_written   <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus answer: never waits, errors on unmapped access
    assign apb_rsp.prdata  = state_reg.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_phase && (bus_sel == sel_none);

    // Outputs straight from flops
    assign demod_phase              = state_reg.demod_phase;
    assign chroma_out               = state_reg.chroma_out;
    assign filter_sel               = state_reg.filter_sel;
    assign peaking_enable           = state_reg.peaking_enable;
    assign chroma_gain_loop_enable  = state_reg.gain_enable;
    assign low_color_removal_enable = state_reg.kill_enable;

    // Write of an odd-field loop byte
    sequence s_odd_write;
        bus_write && bus_sel == sel_odd;
    endsequence

    // Odd field running after that write
    sequence s_odd_field;
        field_odd;
    endsequence

    a_tint_phase_add: assert property ( // R1
        @(posedge clk) disable iff (rst)
        !rst && color_std == std_ntsc |=>
            demod_phase == $past(sc_phase) + tint_offset($past(state_reg.tint)))
        else $error("demod phase lacks tint offset");

    a_tint_min_step: assert property ( // R2
        @(posedge clk) disable iff (rst)
        (color_std == std_ntsc && state_reg.tint == 8'h80) |=>
            demod_phase == $past(sc_phase) - 16'h4000)
        else $error("tint 0x80 not a quarter turn back");

    a_tint_reset_zero: assert property ( // R3
        @(posedge clk) disable iff (rst)
        !state_reg.tint_written |-> state_reg.tint == TINT_RESET)
        else $error("tint not zero before first write");

    a_tint_non_ntsc: assert property ( // R4
        @(posedge clk) disable iff (rst)
        !rst && color_std != std_ntsc |=> demod_phase == $past(sc_phase))
        else $error("tint applied outside NTSC");

    a_odd_copy_used: assert property ( // R13
        @(posedge clk) disable iff (rst)
        s_odd_write ##1 s_odd_field |=>
            peaking_enable == $past(apb_req.pwdata[7], 2))
        else $error("odd field not using odd copy");

    a_gain_unity_pass: assert property ( // R7
        @(posedge clk) disable iff (rst)
        (!rst && active_ctrl.chroma_gain_loop_enable && !active_ctrl.low_color_removal_enable
         && chroma_gain == GAIN_UNITY) |=> chroma_out == $past(chroma_in))
        else $error("unity gain changed chroma");

    a_gain_off_pass: assert property ( // R7
        @(posedge clk) disable iff (rst)
        (!rst && !active_ctrl.chroma_gain_loop_enable && !active_ctrl.low_color_removal_enable)
            |=> chroma_out == $past(chroma_in))
        else $error("chroma altered with gain off");

    a_color_kill: assert property ( // R8
        @(posedge clk) disable iff (rst)
        (active_ctrl.low_color_removal_enable && low_color_detected)
            |=> chroma_out == CHROMA_ZERO)
        else $error("low colour not removed");

    a_auto_filter: assert property ( // R10
        @(posedge clk) disable iff (rst)
        (!rst && !active_ctrl.peak && active_ctrl.horizontal_lowpass_select == HF_AUTO
         && hscale_ratio <= RATIO_EIGHTH) |=> filter_sel == filt_icon)
        else $error("auto mode missed icon filter");

    a_peak_select: assert property ( // R12
        @(posedge clk) disable iff (rst)
        (active_ctrl.peak && active_ctrl.horizontal_lowpass_select == HF_CODE1)
            |=> filter_sel == filt_peak_max_full && peaking_enable)
        else $error("peaking code 01 not max full");

    a_unmapped_write_dropped: assert property ( // R5
        @(posedge clk) disable iff (rst)
        (bus_write && bus_sel == sel_none) |=> $stable(state_reg.tint)
            && $stable(state_reg.even_ctrl) && $stable(state_reg.odd_ctrl))
        else $error("unmapped write changed a register");

endmodule

`default_nettype wire

/* File: test/hue_and_chroma_loop_control_bench.sv */
// Purpose: Self-checking bench for the tint offset and chroma loop control block
// Assumes: Zero-wait APB slave; pixel outputs settle one cycle after their inputs
// Notes:   Table rows first, then bus, refusal and mid-run reset cases by hand

`timescale 1ns/1ps
`default_nettype none

module hue_and_chroma_loop_control_bench
    import hcl_pkg::*;
;

    // One table row: register bytes and decoder inputs, then expected outputs
    typedef struct packed {
        logic [7:0]        tint;
        logic [7:0]        ev;
        logic [7:0]        od;
        logic              fo;
        hcl_std_t          cs;
        logic [15:0]       ph;
        logic [15:0]       ratio;
        logic signed [9:0] cin;
        logic [9:0]        gain;
        logic              low;
        logic [15:0]       eph;
        logic signed [9:0] ech;
        hcl_filter_t       efl;
        logic [2:0]        eflg;
    } hcl_row_t;

    localparam int NROWS = 22;  // Rows in the table
    localparam int WAIT_MAX = 20;  // Bound on any pready wait

    // Clock and reset
    logic              clk;
    logic              rst;
    // Bus request and answer
    hcl_apb_req_t      apb_req;
    hcl_apb_rsp_t      apb_rsp;
    // Decoder side inputs
    logic              field_odd;
    hcl_std_t          color_std;
    logic [15:0]       sc_phase;
    logic [15:0]       hscale_ratio;
    logic signed [9:0] chroma_in;
    logic [9:0]        chroma_gain;
    logic              low_color_detected;
    // Decoder side outputs
    logic [15:0]       demod_phase;
    logic signed [9:0] chroma_out;
    hcl_filter_t       filter_sel;
    logic              peaking_enable;
    logic              chroma_gain_loop_enable;
    logic              low_color_removal_enable;
    // Bookkeeping
    int                errors;
    int                tests_run;
    hcl_row_t          rows [NROWS];
    logic [31:0]       rd;
    logic              err;

    // Device under test
    hcl_loop_control i_dut (
        .clk                      (clk),
        .rst                      (rst),
        .apb_req                  (apb_req),
        .apb_rsp                  (apb_rsp),
        .field_odd                (field_odd),
        .color_std                (color_std),
        .sc_phase                 (sc_phase),
        .hscale_ratio             (hscale_ratio),
        .chroma_in                (chroma_in),
        .chroma_gain              (chroma_gain),
        .low_color_detected       (low_color_detected),
        .demod_phase              (demod_phase),
        .chroma_out               (chroma_out),
        .filter_sel               (filter_sel),
        .peaking_enable           (peaking_enable),
        .chroma_gain_loop_enable  (chroma_gain_loop_enable),
        .low_color_removal_enable (low_color_removal_enable)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // Verdict and end of run, reached from the main flow and from timeouts
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bus results: read data and error flag
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Pixel path results, widened so one task serves all of them
    task automatic chk_pix(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                            output logic [31:0] data, output logic slverr);
        int n;
        @(posedge clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wd;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // Bounded wait; a hang here would otherwise stall the run forever
        for (n = 0; n < WAIT_MAX; n++) begin
            @(posedge clk);
            if (apb_rsp.pready === 1'b1) begin
                break;
            end
        end
        if (n == WAIT_MAX) begin
            errors++;
            $display("Error at %0t: bus answer never came", $time);
            end_sim();
        end
        data   = apb_rsp.prdata;
        slverr = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // Read one register and compare data and error flag
    task automatic read_chk(input logic [11:0] addr, input logic [31:0] exp, input logic eerr);
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        chk_reg(rd, exp, "read data");
        chk_reg({31'h0, err}, {31'h0, eerr}, "slave error");
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        apb_req = '0;
        field_odd = 1'b0;
        color_std = std_ntsc;
        sc_phase = 16'h0000;
        hscale_ratio = 16'h8000;
        chroma_in = 10'h000;
        chroma_gain = 10'h100;
        low_color_detected = 1'b0;
        errors = 0;
        tests_run = 0;
        // Tint, field copies, standards, gain limits, kill priority, filter codes
        rows[0]  = '{8'h80, 8'h00, 8'h00, 1'b0, std_ntsc, 16'h1000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'hd000, 10'h064, filt_none, 3'h0};
        rows[1]  = '{8'h7f, 8'h00, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h4001, 10'h064, 10'h100,
                     1'b0, 16'h3f80, 10'h064, filt_none, 3'h0};
        rows[2]  = '{8'h7f, 8'h00, 8'h00, 1'b0, std_pal, 16'h1234, 16'h4000, 10'h064, 10'h100,
                     1'b0, 16'h1234, 10'h064, filt_cif, 3'h0};
        rows[3]  = '{8'h7f, 8'h00, 8'h00, 1'b0, std_secam, 16'h1111, 16'h2000, 10'h064, 10'h100,
                     1'b0, 16'h1111, 10'h064, filt_qcif, 3'h0};
        rows[4]  = '{8'h7f, 8'h00, 8'h00, 1'b0, std_digital, 16'h2222, 16'h1000, 10'h064,
                     10'h100, 1'b0, 16'h2222, 10'h064, filt_icon, 3'h0};
        rows[5]  = '{8'h01, 8'h80, 8'h40, 1'b0, std_ntsc, 16'hffc0, 16'h8000, 10'h064, 10'h200,
                     1'b0, 16'h0040, 10'h064, filt_peak_min_full, 3'h4};
        rows[6]  = '{8'h01, 8'h80, 8'h40, 1'b1, std_ntsc, 16'hffc0, 16'h8000, 10'h064, 10'h200,
                     1'b0, 16'h0040, 10'h0c8, filt_none, 3'h2};
        rows[7]  = '{8'h01, 8'h80, 8'h40, 1'b1, std_ntsc, 16'h0000, 16'h8000, 10'h12c, 10'h300,
                     1'b0, 16'h0080, 10'h1ff, filt_none, 3'h2};
        rows[8]  = '{8'h01, 8'h80, 8'h40, 1'b1, std_ntsc, 16'h0000, 16'h8000, 10'h2d4, 10'h040,
                     1'b0, 16'h0080, 10'h36a, filt_none, 3'h2};
        rows[9]  = '{8'h01, 8'h80, 8'h40, 1'b1, std_ntsc, 16'h0000, 16'h8000, 10'h2d4, 10'h200,
                     1'b0, 16'h0080, 10'h200, filt_none, 3'h2};
        rows[10] = '{8'h00, 8'h20, 8'h60, 1'b1, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b1, 16'h0000, 10'h000, filt_none, 3'h3};
        rows[11] = '{8'h00, 8'h20, 8'h60, 1'b1, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_none, 3'h3};
        rows[12] = '{8'h00, 8'h20, 8'h60, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b1, 16'h0000, 10'h000, filt_none, 3'h1};
        rows[13] = '{8'h00, 8'h88, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_peak_max_full, 3'h4};
        rows[14] = '{8'h00, 8'h90, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_peak_min_cif, 3'h4};
        rows[15] = '{8'h00, 8'h98, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_peak_min_full, 3'h4};
        rows[16] = '{8'h00, 8'h0f, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_cif, 3'h0};
        rows[17] = '{8'h00, 8'h10, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_qcif, 3'h0};
        rows[18] = '{8'h00, 8'h1f, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_icon, 3'h0};
        rows[19] = '{8'h00, 8'h07, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h8000, 10'h064, 10'h100,
                     1'b1, 16'h0000, 10'h064, filt_none, 3'h0};
        rows[20] = '{8'h00, 8'h00, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h2001, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_cif, 3'h0};
        rows[21] = '{8'h00, 8'h00, 8'h00, 1'b0, std_ntsc, 16'h0000, 16'h1001, 10'h064, 10'h100,
                     1'b0, 16'h0000, 10'h064, filt_qcif, 3'h0};
        // Reset held for twelve cycles, released on an edge
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Luma decimation taken as cleared; load, drive, check one cycle later
        for (int i = 0; i < NROWS; i++) begin
            apb_xfer(1'b1, ADDR_TINT, {24'hffffff, rows[i].tint}, rd, err);
            apb_xfer(1'b1, ADDR_EVEN_LOOP, {24'h0, rows[i].ev}, rd, err);
            apb_xfer(1'b1, ADDR_ODD_LOOP, {24'h0, rows[i].od}, rd, err);
            @(posedge clk);
            field_odd <= rows[i].fo;
            color_std <= rows[i].cs;
            sc_phase <= rows[i].ph;
            hscale_ratio <= rows[i].ratio;
            chroma_in <= rows[i].cin;
            chroma_gain <= rows[i].gain;
            low_color_detected <= rows[i].low;
            @(posedge clk);
            #1;
            chk_pix(demod_phase, rows[i].eph, "phase");
            chk_pix(16'(chroma_out), 16'(rows[i].ech), "chroma");
            chk_pix(16'(filter_sel), 16'(rows[i].efl), "filter");
            chk_pix({13'h0, peaking_enable, chroma_gain_loop_enable, low_color_removal_enable},
                    {13'h0, rows[i].eflg}, "enables");
        end
        apb_xfer(1'b1, ADDR_TINT, 32'hffffffa5, rd, err);
        apb_xfer(1'b1, ADDR_EVEN_LOOP, 32'h1234565a, rd, err);
        apb_xfer(1'b1, ADDR_ODD_LOOP, 32'h000000c3, rd, err);
        read_chk(ADDR_TINT, 32'h000000a5, 1'b0);
        read_chk(ADDR_EVEN_LOOP, 32'h0000005a, 1'b0);
        read_chk(ADDR_ODD_LOOP, 32'h000000c3, 1'b0);
        // Unmapped places refuse writes and flag the access
        apb_xfer(1'b1, 12'h044, 32'h000000ff, rd, err);
        chk_reg({31'h0, err}, 32'h1, "write error");
        read_chk(12'h044, 32'h0, 1'b1);
        read_chk(12'h000, 32'h0, 1'b1);
        read_chk(ADDR_TINT, 32'h000000a5, 1'b0);
        // mid-run reset clears outputs and registers
        @(posedge clk);
        rst <= 1'b1;
        sc_phase <= 16'h4321;
        repeat (2) @(posedge clk);
        #1;
        chk_pix(demod_phase, 16'h0000, "phase in reset");
        chk_pix(16'(filter_sel), 16'(filt_none), "filter in reset");
        @(posedge clk);
        rst <= 1'b0;
        read_chk(ADDR_TINT, 32'h0, 1'b0);
        read_chk(ADDR_EVEN_LOOP, 32'h0, 1'b0);
        read_chk(ADDR_ODD_LOOP, 32'h0, 1'b0);
        // Zero tint leaves the subcarrier phase untouched
        #1;
        chk_pix(demod_phase, 16'h4321, "phase after reset");
        end_sim();
    end

endmodule

`default_nettype wire
